// [core/eprom_prog_map.svh]
`ifndef EPROM_PROG_MAP_SVH
`define EPROM_PROG_MAP_SVH
// clock and pin timing, in nanoseconds as printed
`define CLK_PERIOD_NS 25
`define T_FAST_PULSE_NS 100000
`define T_INT_PULSE_NS 1000000
`define T_OVP_PULSE_NS 2000000
`define T_SETUP_NS 2000
`define T_DATA_HOLD_NS 2000
`define T_DV_NS 250
`define T_ACC_NS 150
// extra cycles for the two-flop data synchroniser plus margin
`define SYNC_CYC 3
// pulse budgets per address
`define FAST_MAX_PULSES 5'h19
`define INT_MAX_PULSES 5'h19
// array shape and erased contents
`define ADDR_W 17
`define DATA_W 8
`define ERASED_BYTE 8'hFF
`endif

// [core/eprom_prog_pkg.sv]
`include "eprom_prog_map.svh"
package eprom_prog_pkg;
  typedef enum logic [1:0] {OP_READ, OP_VERIFY, OP_PROGRAM} op_t;
  typedef enum logic {ALG_FAST, ALG_INTERACTIVE} alg_t;
  typedef struct packed {
    op_t op;
    alg_t alg;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] data;
  } cmd_t;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic program_strobe_n;
    logic vpp_high;
    logic vcc_raise;
  } pin_ctl_t;
endpackage

// [core/eprom_prog_host.sv]
// What this block does
// - program mode: supply high, output gate high, chip select and strobe low
// - byte to write driven on all eight data lines during programming
// - interactive: one short pulse, then read back and compare
// - interactive: retry same address until verified or pulse budget spent
// - interactive: one overprogram pulse per location after it verifies
// - interactive: final verify of array at nominal supply
// - fast: stable address and data, then one 100 us strobe pulse
// - fast: retry on failed readback, at most 25 pulses per address
// - fast: final verify of every address at nominal supply
// - verify: select and gate low, strobe high, supplies at nominal
`include "eprom_prog_map.svh"
module eprom_prog_host #(
  parameter int unsigned INT_PULSE_CYC = `T_INT_PULSE_NS / `CLK_PERIOD_NS,
  parameter int unsigned OVP_PULSE_CYC = `T_OVP_PULSE_NS / `CLK_PERIOD_NS
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cmd_valid,
  input wire eprom_prog_pkg::cmd_t i_cmd,
  output logic o_busy,
  output logic o_done,
  output logic o_fail,
  output logic [`DATA_W-1:0] o_rdata,
  output eprom_prog_pkg::pin_ctl_t o_pins,
  output logic [`ADDR_W-1:0] o_address_lines,
  input wire logic [`DATA_W-1:0] i_data_lines,
  output logic [`DATA_W-1:0] o_data_lines,
  output logic o_data_lines_oe_n
);
  localparam logic [16:0] FAST_CYC = 17'(`T_FAST_PULSE_NS / `CLK_PERIOD_NS);
  localparam logic [16:0] INT_CYC = 17'(INT_PULSE_CYC);
  localparam logic [16:0] OVP_CYC = 17'(OVP_PULSE_CYC);
  localparam logic [16:0] SETUP_CYC = 17'((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  localparam logic [16:0] HOLD_CYC = 17'((`T_DATA_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  localparam logic [16:0] DV_CYC = 17'((`T_DV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + `SYNC_CYC);
  localparam logic [16:0] ACC_CYC = 17'((`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + `SYNC_CYC);

  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_VWAIT, S_READ, S_END} state_t;

  state_t state;
  eprom_prog_pkg::cmd_t cmd;
  logic [16:0] cnt;
  logic [4:0] pulses;
  logic ovp;
  logic [`DATA_W-1:0] data_meta;
  logic [`DATA_W-1:0] data_sync;
  logic [`DATA_W-1:0] rd;
  logic [4:0] max_pulses;
  logic cnt_done;

  // data pins come from another party: two flops before any use
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      data_meta <= 8'h00;
      data_sync <= 8'h00;
    end else begin
      data_meta <= i_data_lines;
      data_sync <= data_meta;
    end
  end

  assign rd = data_sync;
  assign cnt_done = (cnt == 17'h00000);
  assign max_pulses = (cmd.alg == eprom_prog_pkg::ALG_FAST) ? `FAST_MAX_PULSES : `INT_MAX_PULSES;

  // sequencer: pin levels, timers and pulse budget move together
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= S_IDLE;
      cmd <= '0;
      cnt <= 17'h00000;
      pulses <= 5'h00;
      ovp <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_fail <= 1'b0;
      o_rdata <= `ERASED_BYTE;
      o_pins <= 5'h1C; // deselected, gate high, strobe high, supplies nominal
      o_address_lines <= 17'h00000;
      o_data_lines <= `ERASED_BYTE;
      o_data_lines_oe_n <= 1'b1;
    end else begin
      o_done <= 1'b0;
      if (!cnt_done) begin
        cnt <= cnt - 17'h00001;
      end
      case (state)
        S_IDLE: begin
          if (i_cmd_valid) begin
            cmd <= i_cmd;
            o_busy <= 1'b1;
            o_fail <= 1'b0;
            pulses <= 5'h00;
            ovp <= 1'b0;
            o_address_lines <= i_cmd.addr;
            o_pins.ce_n <= 1'b0;
            if (i_cmd.op == eprom_prog_pkg::OP_PROGRAM) begin
              // raised supplies, gate high, byte on the pins before strobing
              o_pins.vpp_high <= 1'b1;
              o_pins.vcc_raise <= 1'b1;
              o_pins.oe_n <= 1'b1;
              o_data_lines <= i_cmd.data;
              o_data_lines_oe_n <= 1'b0;
              cnt <= SETUP_CYC - 17'h00001;
              state <= S_SETUP;
            end else begin
              // read and final verify run at nominal supply
              o_pins.vpp_high <= 1'b0;
              o_pins.vcc_raise <= 1'b0;
              o_pins.oe_n <= 1'b0;
              cnt <= ACC_CYC - 17'h00001;
              state <= S_READ;
            end
          end
        end
        S_SETUP: begin
          if (cnt_done) begin
            o_pins.program_strobe_n <= 1'b0;
            if (!ovp) begin
              pulses <= pulses + 5'h01;
            end
            if (ovp) begin
              cnt <= OVP_CYC - 17'h00001;
            end else if (cmd.alg == eprom_prog_pkg::ALG_FAST) begin
              cnt <= FAST_CYC - 17'h00001;
            end else begin
              cnt <= INT_CYC - 17'h00001;
            end
            state <= S_PULSE;
          end
        end
        S_PULSE: begin
          if (cnt_done) begin
            o_pins.program_strobe_n <= 1'b1;
            cnt <= HOLD_CYC - 17'h00001;
            state <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (cnt_done) begin
            o_data_lines_oe_n <= 1'b1; // release in the same cycle the output gate goes low for readback
            if (ovp) begin
              state <= S_END;
            end else begin
              o_pins.oe_n <= 1'b0;
              cnt <= DV_CYC - 17'h00001;
              state <= S_VWAIT;
            end
          end
        end
        S_VWAIT: begin
          if (cnt_done) begin
            o_rdata <= rd;
            o_pins.oe_n <= 1'b1;
            if (rd == cmd.data) begin
              if (cmd.alg == eprom_prog_pkg::ALG_INTERACTIVE) begin
                ovp <= 1'b1;
                o_data_lines_oe_n <= 1'b0;
                cnt <= SETUP_CYC - 17'h00001;
                state <= S_SETUP;
              end else begin
                state <= S_END;
              end
            end else if (((~rd) & cmd.data) != 8'h00 || pulses == max_pulses) begin
              // a zero cannot return to one, and a spent budget will not help
              o_fail <= 1'b1;
              state <= S_END;
            end else begin
              o_data_lines_oe_n <= 1'b0;
              cnt <= SETUP_CYC - 17'h00001;
              state <= S_SETUP;
            end
          end
        end
        S_READ: begin
          if (cnt_done) begin
            o_rdata <= rd;
            o_fail <= (cmd.op == eprom_prog_pkg::OP_VERIFY) && (rd != cmd.data);
            state <= S_END;
          end
        end
        S_END: begin
          // deselect so a shared bus stays inhibited between commands
          o_pins <= 5'h1C;
          o_data_lines_oe_n <= 1'b1;
          o_busy <= 1'b0;
          o_done <= 1'b1;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // helper: length of the current strobe low phase
  logic [16:0] low_cnt;
  logic [16:0] exp_cyc;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      low_cnt <= 17'h00000;
    end else if (!o_pins.program_strobe_n) begin
      low_cnt <= low_cnt + 17'h00001;
    end else begin
      low_cnt <= 17'h00000;
    end
  end
  assign exp_cyc = ovp ? OVP_CYC : ((cmd.alg == eprom_prog_pkg::ALG_FAST) ? FAST_CYC : INT_CYC);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_program_entry: assert property (!o_pins.program_strobe_n |->
    !o_pins.ce_n && o_pins.oe_n && o_pins.vpp_high) else $error("strobe low outside program mode");
  chk_data_parallel: assert property (!o_pins.program_strobe_n |->
    !o_data_lines_oe_n && o_data_lines == cmd.data) else $error("byte not driven during pulse");
  chk_pulse_width: assert property ($rose(o_pins.program_strobe_n) && o_busy |->
    low_cnt == exp_cyc) else $error("program pulse width wrong");
  chk_pulse_budget: assert property (pulses <= max_pulses) else $error("pulse budget exceeded");
  chk_verify_after: assert property ($rose(o_pins.program_strobe_n) && !ovp |->
    ##[1:200] (!o_pins.oe_n && o_pins.program_strobe_n)) else $error("no readback after pulse");
  chk_verify_pins: assert property (state == S_VWAIT |-> !o_pins.ce_n && !o_pins.oe_n &&
    o_pins.program_strobe_n && o_pins.vpp_high && o_data_lines_oe_n) else $error("verify pins wrong");
  chk_same_address: assert property (o_busy && $past(o_busy) && state != S_IDLE |-> $stable(o_address_lines))
    else $error("address moved during sequence");
  chk_nominal_read: assert property (state == S_READ |->
    !o_pins.vpp_high && !o_pins.vcc_raise) else $error("read not at nominal supply");
  chk_fail_stops: assert property (o_fail && state == S_END |=>
    !o_busy && o_done ##1 o_pins.ce_n) else $error("failure did not stop");
  chk_idle_deselect: assert property (!o_busy |-> o_pins.ce_n && o_data_lines_oe_n)
    else $error("selected while idle");

  cov_fast_ok: cover property (state == S_VWAIT && cnt_done && rd == cmd.data && cmd.alg == eprom_prog_pkg::ALG_FAST);
  cov_retry: cover property (state == S_VWAIT && cnt_done && rd != cmd.data ##1 state == S_SETUP);
  cov_overprogram: cover property ($rose(ovp));
  cov_budget_fail: cover property (o_fail && pulses == max_pulses);
endmodule // eprom_prog_host

// [tb/eprom_dev_model.sv]
// behavioural memory device on the far side of the pin controller
module eprom_dev_model (
  input wire logic i_clk,
  input wire logic i_clr,
  input var int i_needed,
  input wire eprom_prog_pkg::pin_ctl_t i_pins,
  input wire logic [16:0] i_address_lines,
  input wire logic [7:0] i_bus,
  output logic [7:0] o_q,
  output int o_pulses,
  output int o_width
);
  timeunit 1ns;
  timeprecision 1ps;
  bit [7:0] mem_n [0:131071]; // stored inverted so a fresh array reads erased
  logic [7:0] last;
  logic prev_strobe;
  int seen;
  int run;
  // unwritten cells read as all ones
  function automatic logic [7:0] rd(input logic [16:0] a);
    return ~mem_n[a];
  endfunction
  // program on strobe release, only when selected in program mode
  always @(posedge i_clk) begin
    prev_strobe <= i_pins.program_strobe_n;
    if (i_clr) begin
      seen <= 0;
      o_pulses <= 0;
    end else if (!prev_strobe && i_pins.program_strobe_n && !i_pins.ce_n && i_pins.oe_n && i_pins.vpp_high) begin
      o_pulses <= o_pulses + 1;
      seen <= seen + 1;
      if (seen + 1 >= i_needed) mem_n[i_address_lines] <= mem_n[i_address_lines] | ~i_bus;
    end
    if (!i_pins.program_strobe_n) run <= run + 1;
    else if (run != 0) begin
      o_width <= run;
      run <= 0;
    end
    if (!i_pins.ce_n && !i_pins.oe_n) last <= o_q;
  end
  // undriven lines show the inverse of the last byte so stale data never matches
  always @* begin
    o_q = (!i_pins.ce_n && !i_pins.oe_n) ? rd(i_address_lines) : ~last;
  end
endmodule // eprom_dev_model

// [tb/uv_eprom_program_read_control_tb_top.sv]
module uv_eprom_program_read_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp=%h got=%h", n, e, g); end end
  logic i_clk, i_rst_n, cmd_valid, clr, busy, done, fail, host_oe_n, oe_snap;
  eprom_prog_pkg::cmd_t cmd;
  eprom_prog_pkg::pin_ctl_t pins, pin_snap;
  logic [7:0] rdata, host_q, dev_q, bus, data_snap;
  logic [16:0] addr;
  int needed, pulses, width, err_count = 0, total_checks = 0, cycles = 0;
  // shared data wire: host wins while its enable is low
  assign bus = host_oe_n ? dev_q : host_q;
  eprom_prog_host #(.INT_PULSE_CYC(20), .OVP_PULSE_CYC(40)) u_eprom_prog_host (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_busy(busy), .o_done(done), .o_fail(fail), .o_rdata(rdata),
    .o_pins(pins), .o_address_lines(addr), .i_data_lines(bus), .o_data_lines(host_q), .o_data_lines_oe_n(host_oe_n));
  eprom_dev_model u_eprom_dev_model (.i_clk(i_clk), .i_clr(clr), .i_needed(needed), .i_pins(pins),
    .i_address_lines(addr), .i_bus(bus), .o_q(dev_q), .o_pulses(pulses), .o_width(width));
  // 40 MHz clock
  initial begin
    i_clk = 0;
    forever #12.5 i_clk = ~i_clk;
  end
  // hang guard, well above the ~22.5k cycles the tests need
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize();
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one command: issue, snapshot pins after acceptance, wait for done
  task automatic run(input eprom_prog_pkg::op_t op, input eprom_prog_pkg::alg_t alg, input logic [16:0] a,
                     input logic [7:0] d, input int n);
    @(posedge i_clk);
    #1;
    cmd = '{op, alg, a, d};
    needed = n;
    cmd_valid = 1;
    clr = 1;
    @(posedge i_clk);
    #1;
    cmd_valid = 0;
    clr = 0;
    pin_snap = pins;
    data_snap = host_q;
    oe_snap = host_oe_n;
    `CHK("busy", 1'b1, busy)
    `CHK("addr", a, addr)
    for (int k = 0; k < 20000 && done !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
    `CHK("done", 1'b1, done)
    `CHK("released", 1'b0, busy)
    `CHK("end pins", 5'h1C, pins)
    `CHK("bus released", 1'b1, host_oe_n)
  endtask
  task automatic t_read();
    `CHK("idle pins", 5'h1C, pins)
    run(eprom_prog_pkg::OP_READ, eprom_prog_pkg::ALG_FAST, 17'h1FFFF, 8'h00, 1);
    `CHK("read pins", 5'h04, pin_snap)
    `CHK("erased", 8'hFF, rdata)
    `CHK("read fail", 1'b0, fail)
  endtask
  task automatic t_fast();
    run(eprom_prog_pkg::OP_PROGRAM, eprom_prog_pkg::ALG_FAST, 17'h00005, 8'hA5, 2);
    `CHK("prog pins", 5'h0F, pin_snap)
    `CHK("prog data", 8'hA5, data_snap)
    `CHK("data drive", 1'b0, oe_snap)
    `CHK("fast pulses", 2, pulses)
    `CHK("fast width", 1'b1, (width >= 3800 && width <= 4200))
    `CHK("fast fail", 1'b0, fail)
    run(eprom_prog_pkg::OP_VERIFY, eprom_prog_pkg::ALG_FAST, 17'h00005, 8'hA5, 1);
    `CHK("fast verify", 8'hA5, rdata)
    `CHK("fast verify ok", 1'b0, fail)
  endtask
  task automatic t_inter();
    run(eprom_prog_pkg::OP_PROGRAM, eprom_prog_pkg::ALG_INTERACTIVE, 17'h1ABCD, 8'h3C, 3);
    `CHK("int pulses", 4, pulses)
    `CHK("ovp width", 1'b1, (width >= 39 && width <= 41))
    `CHK("int read", 8'h3C, rdata)
    `CHK("int fail", 1'b0, fail)
    run(eprom_prog_pkg::OP_VERIFY, eprom_prog_pkg::ALG_FAST, 17'h1ABCD, 8'h00, 1);
    `CHK("int verify", 8'h3C, rdata)
    `CHK("int verify miss", 1'b1, fail)
  endtask
  // reset in the middle of a pulse: pins fall to standby and nothing is written
  task automatic t_reset();
    @(posedge i_clk);
    #1;
    cmd = '{eprom_prog_pkg::OP_PROGRAM, eprom_prog_pkg::ALG_FAST, 17'h00009, 8'h5A};
    needed = 1;
    cmd_valid = 1;
    clr = 1;
    @(posedge i_clk);
    #1;
    cmd_valid = 0;
    clr = 0;
    repeat (100) @(posedge i_clk);
    #1;
    `CHK("cut strobe", 1'b0, pins.program_strobe_n)
    i_rst_n = 0;
    @(posedge i_clk);
    #1;
    `CHK("reset pins", 5'h1C, pins)
    `CHK("reset busy", 1'b0, busy)
    `CHK("reset drive", 1'b1, host_oe_n)
    @(posedge i_clk);
    #1;
    i_rst_n = 1;
    `CHK("reset pulses", 0, pulses)
    run(eprom_prog_pkg::OP_READ, eprom_prog_pkg::ALG_FAST, 17'h00009, 8'h00, 1);
    `CHK("cut cell", 8'hFF, rdata)
  endtask
  // stubborn cell: budget runs out and the command reports failure
  task automatic t_budget();
    run(eprom_prog_pkg::OP_PROGRAM, eprom_prog_pkg::ALG_INTERACTIVE, 17'h00100, 8'h00, 99);
    `CHK("budget fail", 1'b1, fail)
    `CHK("budget pulses", 25, pulses)
  endtask
  // a zero can never be turned back into a one
  task automatic t_nozero();
    run(eprom_prog_pkg::OP_PROGRAM, eprom_prog_pkg::ALG_FAST, 17'h00007, 8'h00, 1);
    `CHK("zero ok", 1'b0, fail)
    run(eprom_prog_pkg::OP_PROGRAM, eprom_prog_pkg::ALG_FAST, 17'h00007, 8'hFF, 1);
    `CHK("zero to one", 1'b1, fail)
  endtask
  // reset, then the scenarios in turn
  initial begin
    i_rst_n = 0;
    cmd_valid = 0;
    clr = 0;
    needed = 1;
    cmd = '0;
    repeat (4) @(posedge i_clk);
    #1;
    i_rst_n = 1;
    t_read();
    t_fast();
    t_inter();
    t_budget();
    t_nozero();
    t_reset();
    summarize();
  end
endmodule // uv_eprom_program_read_control_tb_top
